//--- rtl/burst_read_config_pkg.sv
package burst_read_config_pkg;

  // ---------------------------------------------------------------
  // configuration field positions (register bit n = address n+2)
  // ---------------------------------------------------------------
  localparam int CFG_W            = 16;
  localparam int ADDR_TO_CFG      = 2;
  localparam int POS_READ_SELECT  = 15;
  localparam int POS_XLAT_HI      = 14;
  localparam int POS_XLAT_LO      = 11;
  localparam int POS_INTER_WORD   = 9;
  localparam int POS_READY_TIMING = 8;
  localparam int POS_BURST_ORDER  = 7;
  localparam int POS_CLOCK_EDGE   = 6;
  localparam int POS_LATCHED_READ = 3;
  localparam int POS_BLEN_HI      = 2;
  localparam int POS_BLEN_LO      = 0;

  // reserved positions ten, five and four always store zero
  localparam logic [15:0] CFG_WRITABLE = 16'hfbcf;
  localparam logic [15:0] CFG_RESET    = 16'h8000;

  // ---------------------------------------------------------------
  // first-access latency codes
  // ---------------------------------------------------------------
  localparam logic [3:0] XLAT_7  = 4'h2;
  localparam logic [3:0] XLAT_8  = 4'h3;
  localparam logic [3:0] XLAT_9  = 4'h4;
  localparam logic [3:0] XLAT_10 = 4'h5;
  localparam logic [3:0] XLAT_11 = 4'h6;
  localparam logic [3:0] XLAT_12 = 4'h9;
  localparam logic [3:0] XLAT_13 = 4'ha;
  localparam logic [3:0] XLAT_13B = 4'hb;
  localparam logic [3:0] XLAT_15 = 4'hd;
  localparam logic [4:0] XLAT_RESERVED_CYCLES = 5'h0f;

  // ---------------------------------------------------------------
  // burst length codes
  // ---------------------------------------------------------------
  localparam logic [2:0] BLEN_1    = 3'h4;
  localparam logic [2:0] BLEN_2    = 3'h5;
  localparam logic [2:0] BLEN_4    = 3'h1;
  localparam logic [2:0] BLEN_8    = 3'h2;
  localparam logic [2:0] BLEN_CONT = 3'h7;

  // ---------------------------------------------------------------
  // read engine states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_LATENCY = 4'b0010,
    ST_BURST   = 4'b0100,
    ST_ASYNC   = 4'b1000
  } read_state_e;

endpackage : burst_read_config_pkg

//--- rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     flush,
  input  wire logic                     inValid,
  output logic                          inReady,
  input  wire logic [WIDTH-1:0]         inData,
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic [WIDTH-1:0]              outData,
  output logic [$clog2(DEPTH+1)-1:0]    level
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [$clog2(DEPTH+1)-1:0] FULL = ($clog2(DEPTH+1))'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;

  assign inReady  = (level != FULL) && !flush;
  assign outValid = (level != '0) && !flush;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
      end
      level <= level + {{($clog2(DEPTH+1)-1){1'b0}}, doWrite}
                     - {{($clog2(DEPTH+1)-1){1'b0}}, doRead};
    end
  end

endmodule : word_fifo

//--- rtl/burst_read_config.sv
// Function
// [RL1] configuration holds until a new load, a reset or reset/power-down
// [RL2] read select one gives asynchronous reads, zero gives synchronous bursts
// [RL3] reset and power-up set read select to one
// [RL4] four-bit code sets address-latch-to-first-data clock count; others reserved
// [RL5] host uses codes 0010, 0101, 0110, 1011 only with continuous bursts
// [RL6] host uses codes 0101, 0110, 1001, 1010 only on a 16-bit bus
// [RL7] inter-word latency one gives a word each edge, two every second edge
// [RL8] inter-word bit and latency code together choose latency one or two
// [RL9] ready low at invalid-data edge, or one clock earlier when bit set
// [RL10] burst order bit: zero interleaved, one sequential
// [RL11] clock edge bit: zero falling edge active, one rising edge active
// [RL12] latched-read bit picks random or latch-controlled async read when asynchronous
// [RL13] burst length caps words delivered before address wraps inside the burst
// [RL14] length codes 100=1, 101=2, 001=4, 010=8, 111=continuous
// [RL15] host treats positions ten, five and four as reserved
// [RL16] mid-band clock with latency two ignores advance on odd cycles
// [RL17] field bit n is captured from address input n plus two
`timescale 1ns/1ps
module burst_read_config
  import burst_read_config_pkg::*;
#(
  parameter int ADDR_W     = 22,
  parameter int DATA_W     = 32,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              resetPowerDown,
  input  wire logic              cfgLoad,
  input  wire logic [ADDR_W:1]   addrIn,
  input  wire logic              chipEnable_n,
  input  wire logic              outputEnable_n,
  input  wire logic              latchEnable_n,
  input  wire logic              burstAdvance_n,
  input  wire logic              burstClk,
  input  wire logic              clockMidBand,
  output logic                   arrayReq,
  output logic [ADDR_W-1:0]      arrayAddr,
  input  wire logic              arrayAck,
  input  wire logic [DATA_W-1:0] arrayData,
  output logic [DATA_W-1:0]      dqOut,
  output logic                   dqOe_n,
  output logic                   validDataReady,
  output logic [CFG_W-1:0]       cfgState
);

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  function automatic logic [4:0] xlat_cycles(input logic [3:0] code);
    case (code)
      XLAT_7:   xlat_cycles = 5'h07;
      XLAT_8:   xlat_cycles = 5'h08;
      XLAT_9:   xlat_cycles = 5'h09;
      XLAT_10:  xlat_cycles = 5'h0a;
      XLAT_11:  xlat_cycles = 5'h0b;
      XLAT_12:  xlat_cycles = 5'h0c;
      XLAT_13:  xlat_cycles = 5'h0d;
      XLAT_13B: xlat_cycles = 5'h0d;
      XLAT_15:  xlat_cycles = 5'h0f;
      default:  xlat_cycles = XLAT_RESERVED_CYCLES;
    endcase
  endfunction : xlat_cycles

  function automatic logic [2:0] blen_mask(input logic [2:0] code);
    case (code)
      BLEN_1:  blen_mask = 3'h0;
      BLEN_2:  blen_mask = 3'h1;
      BLEN_4:  blen_mask = 3'h3;
      BLEN_8:  blen_mask = 3'h7;
      default: blen_mask = 3'h7;
    endcase
  endfunction : blen_mask

  logic [CFG_W-1:0] cfg;
  wire [CFG_W-1:0]  cfgFromAddr = addrIn[CFG_W+ADDR_TO_CFG-1:ADDR_TO_CFG]; // RL17

  wire       readAsync   = cfg[POS_READ_SELECT];                          // RL2
  wire [3:0] xlatCode    = cfg[POS_XLAT_HI:POS_XLAT_LO];
  wire [4:0] xlatCount   = xlat_cycles(xlatCode);                          // RL4
  wire       slowCode    = (xlatCode == XLAT_13B) || (xlatCode == XLAT_15);
  wire       yLatTwo     = slowCode || cfg[POS_INTER_WORD];                // RL8
  wire       readyEarly  = cfg[POS_READY_TIMING];
  wire       orderSeq    = cfg[POS_BURST_ORDER];
  wire       risingEdge  = cfg[POS_CLOCK_EDGE];
  wire       latchedRead = cfg[POS_LATCHED_READ];
  wire [2:0] blenCode    = cfg[POS_BLEN_HI:POS_BLEN_LO];
  wire       blenCont    = (blenCode == BLEN_CONT);                        // RL14
  wire [2:0] blenMask    = blen_mask(blenCode);                            // RL14

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst || resetPowerDown) begin
      cfg <= CFG_RESET;                                                    // RL3
    end else if (cfgLoad) begin
      cfg <= cfgFromAddr & CFG_WRITABLE;                                   // RL1
    end
  end

  // ---------------------------------------------------------------
  // burst clock edge and latch-enable tracking
  // ---------------------------------------------------------------
  logic kPrev;
  logic lePrev;
  wire  kRise      = burstClk && !kPrev;
  wire  kFall      = !burstClk && kPrev;
  wire  activeEdge = risingEdge ? kRise : kFall;                           // RL11
  wire  leRise     = latchEnable_n && !lePrev;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // start from the pin level so reset leaves no false clock edge
      kPrev  <= burstClk;
      lePrev <= 1'b1;
    end else begin
      kPrev  <= burstClk;
      lePrev <= latchEnable_n;
    end
  end

  // ---------------------------------------------------------------
  // read engine
  // ---------------------------------------------------------------
  read_state_e      state;
  logic [ADDR_W-1:0] startAddr;
  logic [ADDR_W-1:0] asyncAddr;
  logic [ADDR_W-1:0] fetchIdx;
  logic [4:0]        latCount;
  logic              cycOdd;
  logic              advPend;
  logic              pending;
  logic              dropNext;

  wire [ADDR_W-1:0] addrWord  = addrIn[ADDR_W:1];
  wire              selected  = !chipEnable_n && !resetPowerDown;
  wire              syncLatch = selected && !readAsync && activeEdge &&
                                (!latchEnable_n || leRise);
  wire              abort     = !selected || readAsync;

  // async address: transparent for random read, held by latch enable otherwise
  wire [ADDR_W-1:0] asyncPick = (latchedRead && latchEnable_n) ? asyncAddr
                                                               : addrWord; // RL12

  // burst address order within the wrap window
  wire [2:0]        idxLow   = fetchIdx[2:0] & blenMask;
  wire [2:0]        seqLow   = (startAddr[2:0] + idxLow) & blenMask;
  wire [2:0]        intLow   = (startAddr[2:0] ^ idxLow) & blenMask;
  wire [2:0]        winLow   = orderSeq ? seqLow : intLow;                 // RL10
  wire [ADDR_W-1:0] wrapAddr = {startAddr[ADDR_W-1:3],
                                (startAddr[2:0] & ~blenMask) | winLow};    // RL13
  wire [ADDR_W-1:0] contAddr = startAddr + fetchIdx;
  wire [ADDR_W-1:0] burstAddr = blenCont ? contAddr : wrapAddr;

  // fifo between array fetches and the data bus
  logic              fifoInReady;
  logic              fifoOutValid;
  logic [DATA_W-1:0] fifoOutData;
  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
  logic [LVL_W-1:0]  fifoLevel;

  wire inBurst    = (state == ST_LATENCY) || (state == ST_BURST);
  wire fetchFire  = inBurst && !pending && fifoInReady && !abort;
  wire asyncFire  = (state == ST_IDLE) && selected && readAsync && !outputEnable_n &&
                    !pending;
  wire ackKeep    = arrayAck && !dropNext;
  wire fifoPush   = ackKeep && inBurst;

  // advance decision on each active edge of the data phase
  wire bSeen      = !burstAdvance_n && !(clockMidBand && yLatTwo && cycOdd); // RL16
  wire firstWord  = (state == ST_LATENCY) && activeEdge && (latCount == 5'h01);
  wire slotOpen   = !yLatTwo || !cycOdd;                                   // RL7
  wire wantAdv    = (state == ST_BURST) && activeEdge && slotOpen && (bSeen || advPend);
  wire presentNow = firstWord || wantAdv;
  wire fifoPop    = presentNow && fifoOutValid && !abort;
  wire nearEmpty  = (fifoLevel < LVL_W'(2)) && !(fifoLevel == LVL_W'(1) && !presentNow);
  wire readyNorm  = fifoOutValid;
  wire readyNext  = readyEarly ? !nearEmpty || arrayAck : readyNorm;       // RL9

  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_word_fifo (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .flush    (abort || syncLatch),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .inData   (arrayData),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData),
    .level    (fifoLevel)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (syncLatch) begin
            state <= ST_LATENCY;
          end else if (asyncFire) begin
            state <= ST_ASYNC;
          end
        end
        ST_LATENCY: begin
          if (abort) begin
            state <= ST_IDLE;
          end else if (firstWord) begin
            state <= ST_BURST;
          end
        end
        ST_BURST: begin
          if (abort) begin
            state <= ST_IDLE;
          end else if (syncLatch) begin
            state <= ST_LATENCY;
          end
        end
        ST_ASYNC: begin
          if (arrayAck) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      startAddr <= '0;
      latCount  <= '0;
      fetchIdx  <= '0;
    end else if (syncLatch) begin
      startAddr <= addrWord;
      latCount  <= xlatCount;                                              // RL4
      fetchIdx  <= '0;
    end else begin
      if ((state == ST_LATENCY) && activeEdge && (latCount != 5'h00)) begin
        latCount <= latCount - 5'h01;
      end
      if (fetchFire) begin
        fetchIdx <= fetchIdx + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || state != ST_BURST) begin
      // the edge after the first word is odd, so words land on even edges
      cycOdd  <= 1'b1;
      advPend <= 1'b0;
    end else if (activeEdge) begin
      cycOdd  <= yLatTwo ? !cycOdd : 1'b0;
      advPend <= !slotOpen && bSeen;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      asyncAddr <= '0;
    end else if (!latchEnable_n) begin
      asyncAddr <= addrWord;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pending  <= 1'b0;
    end else begin
      pending  <= (pending && !arrayAck) || fetchFire || asyncFire;
    end
  end

  // only burst fetches are cancelled; an asynchronous read always lands
  wire cancelFetch = (abort || syncLatch) && (state != ST_ASYNC);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dropNext <= 1'b0;
    end else begin
      dropNext <= pending && !arrayAck && (dropNext || cancelFetch);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      arrayReq <= 1'b0;
    end else if (fetchFire || asyncFire) begin
      arrayReq <= 1'b1;
    end else if (arrayAck) begin
      arrayReq <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      arrayAddr <= '0;
    end else if (fetchFire || asyncFire) begin
      arrayAddr <= asyncFire ? asyncPick : burstAddr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfgState <= CFG_RESET;
    end else begin
      cfgState <= cfg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dqOe_n <= 1'b1;
    end else begin
      dqOe_n <= !(selected && !outputEnable_n);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dqOut <= '0;
    end else if (fifoPop) begin
      dqOut <= fifoOutData;
    end else if ((state == ST_ASYNC) && ackKeep) begin
      dqOut <= arrayData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      validDataReady <= 1'b1;
    end else if (state != ST_BURST && !firstWord) begin
      validDataReady <= 1'b1;
    end else if (activeEdge) begin
      validDataReady <= readyNext;                                       // RL9
    end
  end

endmodule : burst_read_config

//--- verif/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic        clk_sys,
  input  wire logic        arrayReq,
  input  wire logic [21:0] arrayAddr,
  output logic             arrayAck,
  output logic [31:0]      arrayData
);
  logic [1:0] waitCnt;

  initial begin
    arrayAck  = 1'b0;
    arrayData = 32'h0;
    waitCnt   = 2'h0;
  end

  // answers after 0..3 idle cycles; data is inverted once the answer is gone
  always @(posedge clk_sys) begin
    if (arrayAck) begin
      arrayAck  <= 1'b0;
      arrayData <= ~arrayData;
    end else if (arrayReq && waitCnt != 2'h0) begin
      waitCnt <= waitCnt - 2'h1;
    end else if (arrayReq) begin
      arrayAck  <= 1'b1;
      arrayData <= {~arrayAddr[9:0], arrayAddr};
      waitCnt   <= 2'($urandom_range(3));
    end
  end
endmodule : flash_array_model

//--- verif/burst_read_config_monitor.sv
`timescale 1ns/1ps
module burst_read_config_monitor
  import burst_read_config_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 32
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              resetPowerDown,
  input wire logic              cfgLoad,
  input wire logic [ADDR_W:1]   addrIn,
  input wire logic              chipEnable_n,
  input wire logic              outputEnable_n,
  input wire logic              arrayReq,
  input wire logic              arrayAck,
  input wire logic [DATA_W-1:0] arrayData,
  input wire logic [DATA_W-1:0] dqOut,
  input wire logic              dqOe_n,
  input wire logic              validDataReady,
  input wire logic [CFG_W-1:0]  cfgState
);
  wire logic [15:0] cfgFromAddr = addrIn[17:2];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_load;
    cfgLoad && !resetPowerDown;
  endsequence
  sequence s_quiet;
    !cfgLoad && !resetPowerDown;
  endsequence
  sequence s_async_hit;
    cfgState[POS_READ_SELECT] && arrayReq && arrayAck;
  endsequence
  sequence s_async_idle;
    cfgState[POS_READ_SELECT] [*3];
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_CFG_LOAD: assert property (
    s_load |=> ##1 cfgState == ($past(cfgFromAddr, 2) & CFG_WRITABLE))
    else $error("configuration not captured from address inputs");
  AST_CFG_HOLD: assert property (
    s_quiet |=> ##1 $stable(cfgState))
    else $error("configuration changed without a load");
  AST_PWRDN: assert property (
    resetPowerDown |=> ##1 cfgState == CFG_RESET)
    else $error("power-down did not restore configuration");
  AST_RESET: assert property (
    disable iff (1'b0) sys_rst |=> cfgState == CFG_RESET && !arrayReq && dqOe_n
      && validDataReady)
    else $error("reset state wrong");
  AST_CFG_RESERVED: assert property (
    (cfgState & ~CFG_WRITABLE) == 16'h0)
    else $error("reserved configuration bit set");
  AST_OUT_ENABLE: assert property (
    !resetPowerDown |=> dqOe_n == $past(chipEnable_n || outputEnable_n))
    else $error("output enable does not follow chip and output enable");
  AST_ASYNC_DATA: assert property (
    s_async_hit |=> dqOut == $past(arrayData))
    else $error("asynchronous read data not presented");
  AST_READY_ASYNC: assert property (
    s_async_idle |-> validDataReady)
    else $error("ready low outside a burst");
endmodule : burst_read_config_monitor

bind burst_read_config burst_read_config_monitor #(
  .ADDR_W(ADDR_W),
  .DATA_W(DATA_W)
) monitor (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .resetPowerDown(resetPowerDown),
  .cfgLoad(cfgLoad), .addrIn(addrIn), .chipEnable_n(chipEnable_n),
  .outputEnable_n(outputEnable_n), .arrayReq(arrayReq), .arrayAck(arrayAck),
  .arrayData(arrayData), .dqOut(dqOut), .dqOe_n(dqOe_n),
  .validDataReady(validDataReady), .cfgState(cfgState)
);

//--- verif/burst_read_config_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module burst_read_config_tb_top;
  import burst_read_config_pkg::*;
  logic        clk_sys, sys_rst, resetPowerDown, cfgLoad, chipEnable_n, outputEnable_n;
  logic        latchEnable_n, burstAdvance_n, burstClk, clockMidBand;
  logic        arrayReq, arrayAck, dqOe_n, validDataReady;
  logic [22:1] addrIn;
  logic [21:0] arrayAddr, a;
  logic [31:0] arrayData, dqOut, seedVal;
  logic [15:0] cfgState, v;
  int          failures, check_count, cycles;
  logic [3:0]  codes [9] = '{XLAT_7, XLAT_8, XLAT_9, XLAT_10, XLAT_11, XLAT_12, XLAT_13,
                             XLAT_13B, XLAT_15};
  int          lat [9] = '{7, 8, 9, 10, 11, 12, 13, 13, 15};
  logic [2:0]  lens [4] = '{BLEN_1, BLEN_2, BLEN_4, BLEN_8};

  burst_read_config DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .resetPowerDown(resetPowerDown),
    .cfgLoad(cfgLoad), .addrIn(addrIn), .chipEnable_n(chipEnable_n),
    .outputEnable_n(outputEnable_n), .latchEnable_n(latchEnable_n),
    .burstAdvance_n(burstAdvance_n), .burstClk(burstClk), .clockMidBand(clockMidBand),
    .arrayReq(arrayReq), .arrayAddr(arrayAddr), .arrayAck(arrayAck),
    .arrayData(arrayData), .dqOut(dqOut), .dqOe_n(dqOe_n),
    .validDataReady(validDataReady), .cfgState(cfgState));
  flash_array_model array (
    .clk_sys(clk_sys), .arrayReq(arrayReq), .arrayAddr(arrayAddr),
    .arrayAck(arrayAck), .arrayData(arrayData));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic load_cfg(input logic [15:0] c);
    addrIn  = 22'({c, 1'b0});
    cfgLoad = 1'b1;
    tick(1);
    cfgLoad = 1'b0;
    tick(2);
  endtask : load_cfg

  // one active and one inactive burst clock edge, each held four cycles
  task automatic kedge(input logic e);
    burstClk = e;
    tick(4);
    burstClk = ~e;
    tick(4);
  endtask : kedge

  function automatic logic [31:0] exp_word(logic [21:0] s, logic [2:0] bl, logic sq, int w);
    logic [21:0] m;
    logic [21:0] x;
    m = (bl == BLEN_1) ? 22'h0 : (bl == BLEN_2) ? 22'h1 : (bl == BLEN_4) ? 22'h3 : 22'h7;
    x = sq ? s + 22'(w) : s ^ 22'(w);
    x = (bl == BLEN_CONT) ? s + 22'(w) : (s & ~m) | (x & m);
    return {~x[9:0], x};
  endfunction : exp_word

  task automatic burst(input int i);
    logic [15:0] c;
    logic [2:0]  bl;
    logic [21:0] s;
    logic        cont;
    logic        yb;
    int          y;
    cont = codes[i] inside {XLAT_7, XLAT_10, XLAT_11, XLAT_13B};
    bl   = cont ? BLEN_CONT : lens[(i / 2) % 4];
    yb   = i[2] && !(codes[i] inside {XLAT_13B, XLAT_15});
    y    = (yb || codes[i] inside {XLAT_13B, XLAT_15}) ? 2 : 1;
    c    = {1'b0, codes[i], 1'b0, yb, i[3], cont | i[0], i[1], 3'h0, bl};
    s    = 22'($urandom);
    load_cfg(c);
    burstClk = ~c[6];
    tick(2);
    addrIn         = s;
    chipEnable_n   = 1'b0;
    outputEnable_n = 1'b0;
    latchEnable_n  = 1'b0;
    burstClk       = c[6];
    tick(4);
    // raise latch enable on the inactive half so it cannot latch again
    latchEnable_n  = 1'b1;
    burstClk       = ~c[6];
    tick(4);
    repeat (lat[i] - 1) kedge(c[6]);
    `CHK(dqOut !== exp_word(s, bl, c[7], 0), 1'b1)
    for (int w = 0; w < 6; w++) begin
      if (w == 3 && y == 2) begin
        // mid-band clock: an advance seen only on the odd edge is dropped
        clockMidBand = 1'b1;
        kedge(c[6]);
        burstAdvance_n = 1'b1;
        kedge(c[6]);
        `CHK(dqOut, exp_word(s, bl, c[7], 2))
        {clockMidBand, burstAdvance_n} = 2'b00;
      end
      if (w > 0 && y == 2) begin
        kedge(c[6]);
        `CHK(dqOut, exp_word(s, bl, c[7], w - 1))
      end
      if (w == 3 && y == 1) begin
        burstAdvance_n = 1'b1;
        repeat (3) kedge(c[6]);
        `CHK(dqOut, exp_word(s, bl, c[7], 2))
        burstAdvance_n = 1'b0;
      end
      kedge(c[6]);
      `CHK(dqOut, exp_word(s, bl, c[7], w))
      `CHK(validDataReady, 1'b1)
    end
    chipEnable_n = 1'b1;
    tick(4);
    $display("test burst %0d done", i);
  endtask : burst

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    {sys_rst, burstClk, clockMidBand, cfgLoad, resetPowerDown} = 5'h10;
    {chipEnable_n, outputEnable_n, latchEnable_n, burstAdvance_n} = 4'he;
    addrIn  = 22'h0;
    seedVal = $urandom(32'hd98ed87c);
    tick(6);
    sys_rst = 1'b0;
    tick(1);
    `CHK(cfgState, CFG_RESET)
    `CHK(dqOe_n, 1'b1)
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 16'hffff : 16'($urandom);
      load_cfg(v);
      `CHK(cfgState, v & CFG_WRITABLE)
    end
    addrIn  = 22'h2aaaa;
    cfgLoad = 1'b1;
    tick(1);
    addrIn = 22'h15554;
    tick(1);
    cfgLoad = 1'b0;
    addrIn  = 22'h3ffff;
    tick(6);
    `CHK(cfgState, 16'haaaa & CFG_WRITABLE)
    resetPowerDown = 1'b1;
    tick(1);
    resetPowerDown = 1'b0;
    tick(2);
    `CHK(cfgState, CFG_RESET)
    $display("test config done");
    for (int k = 0; k < 4; k++) begin
      load_cfg(k[0] ? 16'h8008 : CFG_RESET);
      a             = 22'($urandom);
      addrIn        = a;
      latchEnable_n = 1'b0;
      tick(1);
      latchEnable_n = 1'b1;
      tick(1);
      if (k[0]) addrIn = ~a;
      chipEnable_n   = 1'b0;
      outputEnable_n = 1'b0;
      tick(12);
      `CHK(dqOut, {~a[9:0], a})
      `CHK(dqOe_n, 1'b0)
      chipEnable_n   = 1'b1;
      outputEnable_n = 1'b1;
      tick(3);
    end
    $display("test async done");
    for (int i = 0; i < 9; i++) burst(i);
    final_report();
  end
endmodule : burst_read_config_tb_top
